// [logic/amfs_sequencer.sv]
// Mode and fault sequencer for a two channel class-D amplifier
`timescale 1ns/10ps
`default_nettype none
module amfs_sequencer #(
    parameter int unsigned RESTART_CYCLES = amfs_pkg::RESTART_CYC,
    parameter int unsigned MUTE_CYCLES = amfs_pkg::MUTE_HOLD_CYC,
    parameter int unsigned TAU_CYCLES = amfs_pkg::TAU_CYC,
    parameter int unsigned CARRIER_HALF = amfs_pkg::CARRIER_HALF_CYC
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Mode input from the controller, already quantised
    input wire amfs_pkg::amfs_mode_t MODE_LEVEL,
    // Optional external switching clock
    input wire logic EXT_CLK_SEL,
    input wire logic EXT_CLK,
    // Fault detectors (asynchronous)
    input wire logic TEMP_FOLD,
    input wire logic TEMP_SHUTDOWN,
    input wire logic CURRENT_LIMIT,
    input wire logic LOAD_SHORT,
    input wire logic RAIL_SHORT,
    input wire logic SUPPLY_LOW,
    input wire logic SUPPLY_HIGH,
    input wire logic SUPPLY_IMBALANCE,
    // Outputs
    output logic POWER_STAGE_EN,
    output logic SWITCH_EN,
    output logic CARRIER,
    output logic [amfs_pkg::BIAS_W-1:0] VI_BIAS,
    output logic [amfs_pkg::GAIN_W-1:0] GAIN,
    output logic FAULT_REPORT,
    output logic STANDBY_OUT
);
    import amfs_pkg::*;

    // ----------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
    assign raw_in = {EXT_CLK, TEMP_FOLD, TEMP_SHUTDOWN, CURRENT_LIMIT,
                     LOAD_SHORT, RAIL_SHORT, SUPPLY_LOW, SUPPLY_HIGH,
                     SUPPLY_IMBALANCE};

    // Accept a change once stages two and three agree
    always_comb begin
        filt_next = filt_reg;
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                filt_next[i] = s2_reg[i];
            end
        end
    end

    // Three flop chain per input
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    logic ext_clk_s, fold_s, otp_s, ilim_s, lshort_s, rshort_s;
    logic uv_s, ov_s, ub_s, supply_bad;
    assign {ext_clk_s, fold_s, otp_s, ilim_s, lshort_s, rshort_s,
            uv_s, ov_s, ub_s} = filt_reg;
    assign supply_bad = uv_s | ov_s | ub_s;

    // ----------------------------------------------------------
    // Carrier generation
    // ----------------------------------------------------------
    logic [CNT_W-1:0] osc_cnt_reg, osc_cnt_next;
    logic carrier_reg, carrier_next, ext_prev_reg, ext_prev_next;
    logic car_out_reg, car_out_next;

    // divide by two: carrier toggles on each rising ext edge
    // duty free: only rising edges are used
    // internal: half period count sets 345 kHz
    always_comb begin
        osc_cnt_next = osc_cnt_reg;
        carrier_next = carrier_reg;
        ext_prev_next = ext_clk_s;
        if (EXT_CLK_SEL) begin
            osc_cnt_next = '0;
            if (ext_clk_s && !ext_prev_reg) begin
                carrier_next = !carrier_reg;
            end
        end else if (osc_cnt_reg >= CNT_W'(CARRIER_HALF - 1)) begin
            osc_cnt_next = '0;
            carrier_next = !carrier_reg;
        end else begin
            osc_cnt_next = osc_cnt_reg + 1'b1;
        end
    end

    // Carrier registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_cnt_reg <= '0;
            carrier_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            osc_cnt_reg <= osc_cnt_next;
            carrier_reg <= carrier_next;
            ext_prev_reg <= ext_prev_next;
        end
    end

    // ----------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------
    amfs_state_t st_reg, st_next;
    logic [CNT_W-1:0] tmr_reg, tmr_next;
    logic [CNT_W-1:0] tau_reg, tau_next;
    logic ocp_trip_reg, ocp_trip_next;
    logic [BIAS_W-1:0] bias_reg, bias_next;
    logic [GAIN_W-1:0] gain_reg, gain_next;
    logic pwr_reg, pwr_next, sw_reg, sw_next, flt_reg, flt_next;
    logic sb_reg, sb_next;
    logic hard_fault;

    // load short, overtemp, supply: full shutdown causes
    assign hard_fault = otp_s | supply_bad | lshort_s;

    always_comb begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        tau_next = '0;
        ocp_trip_next = ocp_trip_reg;
        bias_next = bias_reg;
        gain_next = gain_reg;
        case (st_reg)
            AMFS_ST_STANDBY: begin
                bias_next = BIAS_RST;
                if (MODE_LEVEL != AMFS_MODE_STANDBY) begin
                    st_next = AMFS_ST_CHECK;
                end
            end
            // power stages stay off while checking
            AMFS_ST_CHECK: begin
                tmr_next = '0;
                if (MODE_LEVEL == AMFS_MODE_STANDBY) begin
                    st_next = AMFS_ST_STANDBY;
                end else if (!rshort_s) begin
                    st_next = AMFS_ST_MUTE_HOLD;
                end
            end
            AMFS_ST_MUTE_HOLD: begin
                bias_next = BIAS_RST;
                tmr_next = tmr_reg + 1'b1;
                if (MODE_LEVEL == AMFS_MODE_STANDBY) begin
                    st_next = AMFS_ST_STANDBY;
                end else if (hard_fault) begin
                    st_next = AMFS_ST_SHUTDOWN;
                end else if (tmr_reg >= CNT_W'(MUTE_CYCLES - 1)) begin
                    st_next = AMFS_ST_RUN;
                end
            end
            AMFS_ST_RUN: begin
                // bias ramps one step per cycle: up to max in operate, down to zero in mute
                if (MODE_LEVEL == AMFS_MODE_OPERATE) begin
                    if (bias_reg != '1) begin
                        bias_next = bias_reg + 1'b1;
                    end
                end else if (bias_reg != '0) begin
                    bias_next = bias_reg - 1'b1;
                end
                if (ilim_s) begin
                    tau_next = tau_reg + 1'b1;
                end
                if (MODE_LEVEL == AMFS_MODE_STANDBY) begin
                    st_next = AMFS_ST_STANDBY;
                end else if (hard_fault ||
                             (ilim_s && tau_reg >= CNT_W'(TAU_CYCLES - 1)))
                begin
                    ocp_trip_next = ilim_s | lshort_s;
                    st_next = AMFS_ST_SHUTDOWN;
                end
            end
            // shared timer held at zero while a hard fault (overtemp, supply, load short) stands
            AMFS_ST_SHUTDOWN: begin
                bias_next = BIAS_RST;
                tmr_next = '0;
                if (!hard_fault) begin
                    st_next = AMFS_ST_RESTART;
                end
            end
            AMFS_ST_RESTART: begin
                tmr_next = tmr_reg + 1'b1;
                if (hard_fault) begin
                    st_next = AMFS_ST_SHUTDOWN;
                end else if (tmr_reg >= CNT_W'(RESTART_CYCLES - 1)) begin
                    ocp_trip_next = 1'b0;
                    st_next = AMFS_ST_CHECK;
                end
            end
            default: begin
                st_next = AMFS_ST_STANDBY;
            end
        endcase
        if (fold_s) begin
            gain_next = (gain_reg > GAIN_FOLD) ? gain_reg - 1'b1 : GAIN_FOLD;
        end else if (gain_reg != GAIN_FULL) begin
            gain_next = gain_reg + 1'b1;
        end
    end

    // Output decode from next state
    always_comb begin
        pwr_next = (st_next == AMFS_ST_MUTE_HOLD) || (st_next == AMFS_ST_RUN);
        sw_next = pwr_next;
        sb_next = (st_next == AMFS_ST_STANDBY);
        // fault pin shows limiting and guard trip
        flt_next = ilim_s | ocp_trip_next;
        // Carrier pin gated by the switch enable, registered
        car_out_next = carrier_next & sw_next;
    end

    // Sequencer registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= AMFS_ST_STANDBY;
            tmr_reg <= '0;
            tau_reg <= '0;
            ocp_trip_reg <= 1'b0;
            bias_reg <= BIAS_RST;
            gain_reg <= GAIN_FULL;
            pwr_reg <= 1'b0;
            sw_reg <= 1'b0;
            flt_reg <= 1'b0;
            sb_reg <= 1'b1;
            car_out_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            tau_reg <= tau_next;
            ocp_trip_reg <= ocp_trip_next;
            bias_reg <= bias_next;
            gain_reg <= gain_next;
            pwr_reg <= pwr_next;
            sw_reg <= sw_next;
            flt_reg <= flt_next;
            sb_reg <= sb_next;
            car_out_reg <= car_out_next;
        end
    end

    assign POWER_STAGE_EN = pwr_reg;
    assign SWITCH_EN = sw_reg;
    assign CARRIER = car_out_reg;
    assign VI_BIAS = bias_reg;
    assign GAIN = gain_reg;
    assign FAULT_REPORT = flt_reg;
    assign STANDBY_OUT = sb_reg;

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    sequence s_check_pass;
        st_reg == AMFS_ST_CHECK && !rshort_s;
    endsequence

    chk_check_no_power: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        st_reg == AMFS_ST_CHECK |-> !POWER_STAGE_EN)
        else $error("power stage on during rail check");
    chk_rail_short_hold: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        st_reg == AMFS_ST_CHECK && rshort_s && MODE_LEVEL != AMFS_MODE_STANDBY
        |=> st_reg == AMFS_ST_CHECK)
        else $error("start-up passed a rail short");
    chk_check_to_mute: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_check_pass and MODE_LEVEL != AMFS_MODE_STANDBY
        |=> st_reg == AMFS_ST_MUTE_HOLD)
        else $error("no mute hold after check");
    chk_mute_bias_zero: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        st_reg == AMFS_ST_MUTE_HOLD |=> VI_BIAS == BIAS_RST)
        else $error("bias nonzero in mute hold");
    chk_fault_stop: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        st_reg == AMFS_ST_RUN && otp_s |-> ##1 !SWITCH_EN)
        else $error("switching continued over temperature");
    chk_restart_check: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        st_reg == AMFS_ST_RESTART
        |=> st_reg inside {AMFS_ST_RESTART, AMFS_ST_SHUTDOWN, AMFS_ST_CHECK})
        else $error("restart bypassed the rail check");
    chk_fault_pin: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        ilim_s |=> FAULT_REPORT)
        else $error("limit not on fault pin");
    chk_fold_gain: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        fold_s && GAIN > GAIN_FOLD |=> GAIN == $past(GAIN) - 8'h01)
        else $error("gain not stepping down gradually");
    chk_shutdown_wait: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        st_reg == AMFS_ST_SHUTDOWN && hard_fault |=> st_reg == AMFS_ST_SHUTDOWN)
        else $error("left shutdown with fault present");
endmodule
`default_nettype wire

// [logic/amfs_pkg.sv]
// Package: constants and types for the amplifier mode and fault sequencer
package amfs_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 25000000;
    // Restart delay after a cleared shutdown fault or current limit trip
    localparam int unsigned RESTART_MS = 100;
    localparam int unsigned RESTART_CYC = CLK_HZ / 1000 * RESTART_MS;
    // Mute hold for coupling capacitor charge
    localparam int unsigned MUTE_HOLD_MS = 100;
    localparam int unsigned MUTE_HOLD_CYC = CLK_HZ / 1000 * MUTE_HOLD_MS;
    // Current limit time constant tau
    localparam int unsigned TAU_US = 1000;
    localparam int unsigned TAU_CYC = CLK_HZ / 1000000 * TAU_US;
    // Carrier defaults: 345 kHz with 30 kohm resistor
    localparam int unsigned CARRIER_HZ = 345000;
    localparam int unsigned CARRIER_HALF_CYC = CLK_HZ / (2 * CARRIER_HZ);
    // Widths
    localparam int unsigned CNT_W = 24;
    localparam int unsigned BIAS_W = 8;
    localparam int unsigned GAIN_W = 8;
    // Reset values
    localparam logic [BIAS_W-1:0] BIAS_RST = 8'h00;
    localparam logic [GAIN_W-1:0] GAIN_FULL = 8'hFF;
    // Gain at foldback point: 6 dB down is half scale
    localparam logic [GAIN_W-1:0] GAIN_FOLD = 8'h80;
    // Mode input levels
    typedef enum logic [1:0] {
        AMFS_MODE_STANDBY,
        AMFS_MODE_MUTE,
        AMFS_MODE_OPERATE
    } amfs_mode_t;
    // Sequencer states
    typedef enum logic [2:0] {
        AMFS_ST_STANDBY,
        AMFS_ST_CHECK,
        AMFS_ST_MUTE_HOLD,
        AMFS_ST_RUN,
        AMFS_ST_SHUTDOWN,
        AMFS_ST_RESTART
    } amfs_state_t;
endpackage

// [testbench/amfs_ctrl_model.sv]
// Board controller model: mode pin ramp and external switching clock
`timescale 1ns/10ps
`default_nettype none
module amfs_ctrl_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the bench
    input wire amfs_pkg::amfs_mode_t want_mode,
    input wire logic ext_on,
    // Pins toward the sequencer
    output var amfs_pkg::amfs_mode_t mode_level,
    output logic ext_sel,
    output logic ext_clk
);
    import amfs_pkg::*;
    logic [3:0] step_reg;
    logic [3:0] ph_reg;
    // slow ramp, one level per 4 cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_reg <= 4'h0;
            mode_level <= AMFS_MODE_STANDBY;
        end else if (mode_level == want_mode) begin
            step_reg <= 4'h0;
        end else if (step_reg != 4'h3) begin
            step_reg <= step_reg + 4'h1;
        end else begin
            step_reg <= 4'h0;
            mode_level <= (want_mode > mode_level) ?
                amfs_mode_t'(mode_level + 2'h1) :
                amfs_mode_t'(mode_level - 2'h1);
        end
    end
    // shared clock, period 12, uneven duty, still when off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg <= 4'h0;
            ext_sel <= 1'b0;
            ext_clk <= 1'b0;
        end else begin
            ext_sel <= ext_on;
            ph_reg <= (!ext_on || ph_reg == 4'hB) ? 4'h0 : ph_reg + 4'h1;
            ext_clk <= ext_on && (ph_reg < 4'h4);
        end
    end
endmodule
`default_nettype wire

// [testbench/amp_mode_fault_sequencer_tb.sv]
// Self-checking bench for the mode and fault sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    err_count++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end end
module amp_mode_fault_sequencer_tb;
    import amfs_pkg::*;
    localparam int RST_C = 20;
    localparam int CAR_H = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    amfs_mode_t want = AMFS_MODE_STANDBY;
    amfs_mode_t mode_level;
    logic ext_on = 1'b0;
    logic ext_sel, ext_clk;
    logic fold = 1'b0, climit = 1'b0, lshort = 1'b0, rshort = 1'b0;
    logic [3:0] flt = 4'h0;
    logic pse, swe, carrier, fault, stby;
    logic [7:0] bias, gain;
    int err_count = 0;
    int checked = 0;
    int n;
    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    always #20 clk = ~clk;
    amfs_ctrl_model i_ctrl (.clk(clk), .rst_n(rst_n), .want_mode(want),
        .ext_on(ext_on), .mode_level(mode_level), .ext_sel(ext_sel),
        .ext_clk(ext_clk));
    amfs_sequencer #(.RESTART_CYCLES(RST_C), .MUTE_CYCLES(20),
        .TAU_CYCLES(8), .CARRIER_HALF(CAR_H)) i_dut (.REF_CLK(clk),
        .RST_N(rst_n), .MODE_LEVEL(mode_level), .EXT_CLK_SEL(ext_sel),
        .EXT_CLK(ext_clk), .TEMP_FOLD(fold), .TEMP_SHUTDOWN(flt[3]),
        .CURRENT_LIMIT(climit), .LOAD_SHORT(lshort), .RAIL_SHORT(rshort),
        .SUPPLY_LOW(flt[2]), .SUPPLY_HIGH(flt[1]),
        .SUPPLY_IMBALANCE(flt[0]), .POWER_STAGE_EN(pse),
        .SWITCH_EN(swe), .CARRIER(carrier), .VI_BIAS(bias), .GAIN(gain),
        .FAULT_REPORT(fault), .STANDBY_OUT(stby));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wait_en(input logic want_v, output int k);
        k = 0;
        while (swe !== want_v && k < 400) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic carrier_gap(output int k);
        int r[$];
        logic prev;
        prev = 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if (carrier === 1'b1 && prev === 1'b0) r.push_back(i);
            prev = carrier;
        end
        k = (r.size() > 1) ? r[1] - r[0] : 0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_startup;
        @(posedge clk) want <= AMFS_MODE_MUTE;
        wait_en(1'b1, n);
        `CHK("stages on in mute", 1'b1, pse)
        `CHK("bias in mute", 8'h00, bias)
        `CHK("standby out", 1'b0, stby)
        @(posedge clk) want <= AMFS_MODE_OPERATE;
        repeat (6) @(negedge clk);
        `CHK("bias held by mute", 8'h00, bias)
        repeat (320) @(negedge clk);
        `CHK("bias at max", 8'hFF, bias)
        $display("test startup done");
    endtask
    task automatic t_carrier;
        @(posedge clk) ext_on <= 1'b1;
        repeat (30) @(negedge clk);
        carrier_gap(n);
        `CHK("carrier period", 24, n)
        @(posedge clk) ext_on <= 1'b0;
        repeat (10) @(negedge clk);
        carrier_gap(n);
        `CHK("internal carrier period", 2 * CAR_H, n)
        $display("test carrier done");
    endtask
    task automatic t_rail_start;
        @(posedge clk) want <= AMFS_MODE_STANDBY;
        wait_en(1'b0, n);
        repeat (20) @(negedge clk);
        `CHK("standby out", 1'b1, stby)
        @(posedge clk) rshort <= 1'b1;
        want <= AMFS_MODE_MUTE;
        repeat (60) @(negedge clk);
        `CHK("start held by rail short", 1'b0, pse)
        @(posedge clk) rshort <= 1'b0;
        wait_en(1'b1, n);
        `CHK("start after clear", 1'b1, n <= 20)
        @(posedge clk) want <= AMFS_MODE_OPERATE;
        repeat (320) @(negedge clk);
        $display("test rail_start done");
    endtask
    task automatic t_fold;
        @(posedge clk) fold <= 1'b1;
        repeat (20) @(negedge clk);
        `CHK("gain gradual", 1'b1, gain < 8'hFF && gain > 8'h80)
        repeat (200) @(negedge clk);
        `CHK("gain folded", GAIN_FOLD, gain)
        `CHK("still switching", 1'b1, swe)
        @(posedge clk) fold <= 1'b0;
        repeat (200) @(negedge clk);
        `CHK("gain restored", GAIN_FULL, gain)
        $display("test fold done");
    endtask
    task automatic t_faults;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) flt <= 4'h1 << i;
            wait_en(1'b0, n);
            `CHK("fault stops", 1'b1, n <= 8)
            @(posedge clk) flt <= 4'h0;
            wait_en(1'b1, n);
            `CHK("restart delay", 1'b1, n >= RST_C && n <= RST_C + 12)
        end
        @(posedge clk) flt <= 4'h4;
        repeat (10) @(posedge clk);
        flt <= 4'h0;
        repeat (10) @(posedge clk);
        flt <= 4'h4;
        repeat (10) @(posedge clk);
        flt <= 4'h0;
        wait_en(1'b1, n);
        `CHK("timer restarted", 1'b1, n >= RST_C && n <= RST_C + 12)
        $display("test faults done");
    endtask
    task automatic t_climit;
        repeat (60) @(posedge clk) climit <= 1'b1;
        repeat (5) @(posedge clk) climit <= 1'b0;
        repeat (40) @(negedge clk);
        @(posedge clk) climit <= 1'b1;
        repeat (6) @(negedge clk);
        `CHK("limit reported", 1'b1, fault)
        `CHK("limit keeps switching", 1'b1, swe)
        @(posedge clk) climit <= 1'b0;
        repeat (20) @(negedge clk);
        `CHK("no shutdown", 1'b1, swe)
        @(posedge clk) climit <= 1'b1;
        wait_en(1'b0, n);
        `CHK("shut after tau", 1'b1, n >= 8 && n <= 20)
        `CHK("trip reported", 1'b1, fault)
        @(posedge clk) climit <= 1'b0;
        wait_en(1'b1, n);
        `CHK("restart after trip", 1'b1, n <= RST_C + 12)
        $display("test climit done");
    endtask
    task automatic t_load_short;
        @(posedge clk) lshort <= 1'b1;
        wait_en(1'b0, n);
        `CHK("load short stops", 1'b1, n <= 8)
        @(posedge clk) rshort <= 1'b1;
        lshort <= 1'b0;
        repeat (80) @(negedge clk);
        `CHK("restart checks rail", 1'b0, pse)
        @(posedge clk) rshort <= 1'b0;
        wait_en(1'b1, n);
        `CHK("start after clear", 1'b1, n <= 20)
        $display("test load_short done");
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_startup();
        t_carrier();
        t_rail_start();
        t_fold();
        t_faults();
        t_climit();
        t_load_short();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("[FAIL] watchdog expected 0 seen 1");
        wrap_up();
    end
endmodule
`default_nettype wire
